//--- rtl/uwd_watchdog.sv
// User watchdog of the remote-upgrade circuit, with register port and interrupt.
// Assumes pins arrive asynchronous to clk; crcError and coreReconfig come from clk logic.
// Operation
// - Counter counts down from the timeout held in the control register.
// - Counter is 29 bits wide.
// - Only upper 12 timeout bits programmable; low 17 bits are a fixed pattern.
// - Count ticks come from the internal oscillator or the user clock pin.
// - No counting until the device is in user mode.
// - Expiry sets the timeout flag and reconfigures from the factory image.
// - Status is updated before the factory image starts loading.
// - Control cleared after reconfiguration, except core trigger loads update register.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "uwd_cfg.svh"

module uwd_watchdog (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [`UWD_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [31:0] regRdData,
  // Pins
  input wire logic watchdog_reload_n,
  input wire logic intOscClk,
  input wire logic user_clock_pin,
  input wire logic userMode,
  input wire logic config_request_n,
  input wire logic config_status_n,
  // Fabric-side triggers
  input wire logic crcError,
  input wire logic coreReconfig,
  // Reconfiguration engine
  output logic watchdogTimeout,
  output logic factoryLoad,
  // Interrupt
  output logic irq
);
  import uwd_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [`UWD_CNT_W-1:0] uwdLoad(input logic [`UWD_TMO_W-1:0] tmo);
    uwdLoad = {tmo, `UWD_LOW_PATTERN};
  endfunction

  function automatic logic isWr(input logic stb, input logic [`UWD_ADDR_W-1:0] a,
                                input logic [`UWD_ADDR_W-1:0] ofs);
    isWr = stb && (a == ofs);
  endfunction

  localparam logic [`UWD_HOLD_W-1:0] RELOAD_CYC = `UWD_HOLD_W'(`UWD_RELOAD_CYC);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign pinRaw = {config_status_n, config_request_n, userMode, user_clock_pin, intOscClk, watchdog_reload_n};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pinRaw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic reloadLow, oscS, usrS, userModeS, cfgReqS, cfgStatS;
  assign reloadLow = ~sync2_q[0];
  assign oscS = sync2_q[1];
  assign usrS = sync2_q[2];
  assign userModeS = sync2_q[3];
  assign cfgReqS = sync2_q[4];
  assign cfgStatS = sync2_q[5];

  // ****************************************
  // Registers
  // ****************************************
  logic [`UWD_CTRL_W-1:0] ctrl_q;
  logic [`UWD_CTRL_W-1:0] update_q;
  logic flag_q;
  uwd_cause_e cause_q;
  logic [`UWD_IRQ_W-1:0] irqStat_q;
  logic [`UWD_IRQ_W-1:0] irqMask_q;
  logic [`UWD_CNT_W-1:0] cnt_q;
  uwd_state_e state_q;

  logic [`UWD_TMO_W-1:0] tmoVal;
  assign tmoVal = ctrl_q[`UWD_TMO_W-1:0];

  // ****************************************
  // Count tick source
  // ****************************************
  // Edge detect on the synced clock; a user clock above half of clk will alias
  logic srcPrev_q;
  logic srcSel;
  logic tick;
  assign srcSel = ctrl_q[`UWD_CTRL_CLKSEL] ? usrS : oscS;
  assign tick = srcSel && !srcPrev_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      srcPrev_q <= 1'b1;
    end else begin
      srcPrev_q <= srcSel;
    end
  end

  // ****************************************
  // Reload strobe qualification
  // ****************************************
  logic [`UWD_HOLD_W-1:0] lowCnt_q;
  logic reloadFire;
  // Fires once per strobe, on the first cycle the low time is long enough
  assign reloadFire = reloadLow && (lowCnt_q == RELOAD_CYC - 1'b1);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lowCnt_q <= '0;
    end else if (!reloadLow) begin
      lowCnt_q <= '0;
    end else if (lowCnt_q != RELOAD_CYC) begin
      lowCnt_q <= lowCnt_q + 1'b1;
    end
  end

  // ****************************************
  // External reconfiguration triggers
  // ****************************************
  logic cfgReqPrev_q, cfgStatPrev_q;
  logic trigCfgReq, trigStat, extTrig;
  uwd_cause_e extCause;
  assign trigCfgReq = !cfgReqS && cfgReqPrev_q;
  assign trigStat = !cfgStatS && cfgStatPrev_q;
  assign extTrig = trigCfgReq || trigStat || crcError || coreReconfig;

  always_comb begin
    if (trigCfgReq) begin
      extCause = CAUSE_CFGREQ;
    end else if (trigStat) begin
      extCause = CAUSE_STATUS;
    end else if (crcError) begin
      extCause = CAUSE_CRC;
    end else if (coreReconfig) begin
      extCause = CAUSE_CORE;
    end else begin
      extCause = CAUSE_NONE;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgReqPrev_q <= 1'b1;
      cfgStatPrev_q <= 1'b1;
    end else begin
      cfgReqPrev_q <= cfgReqS;
      cfgStatPrev_q <= cfgStatS;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else if (extTrig) begin
      state_q <= ST_EXIT;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (userModeS && ctrl_q[`UWD_CTRL_ENABLE]) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!userModeS) begin
            state_q <= ST_EXIT;
          end else if (!reloadFire && cnt_q == '0) begin
            state_q <= ST_FLAG;
          end
        end
        ST_FLAG: state_q <= ST_LOAD;
        ST_LOAD: state_q <= ST_EXIT;
        ST_EXIT: begin
          if (!userModeS) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Down-counter
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (state_q == ST_IDLE) begin
      cnt_q <= uwdLoad(tmoVal);
    end else if (state_q == ST_RUN) begin
      if (reloadFire) begin
        cnt_q <= uwdLoad(tmoVal);
      end else if (tick && cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign watchdogTimeout = (state_q == ST_FLAG);
  assign factoryLoad = (state_q == ST_LOAD);

  // ****************************************
  // Control and update registers
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `UWD_CTRL_RESET;
    end else if (extTrig) begin
      ctrl_q <= (extCause == CAUSE_CORE) ? update_q : '0;
    end else if (state_q == ST_LOAD) begin
      ctrl_q <= '0;
    end else if (isWr(regWrStrobe, regAddr, `UWD_OFS_CTRL)) begin
      ctrl_q <= regWrData[`UWD_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      update_q <= `UWD_CTRL_RESET;
    end else if (isWr(regWrStrobe, regAddr, `UWD_OFS_UPDATE)) begin
      update_q <= regWrData[`UWD_CTRL_W-1:0];
    end
  end

  // ****************************************
  // Status: timeout flag and cause
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else if (state_q == ST_RUN && userModeS && !extTrig && !reloadFire && cnt_q == '0) begin
      flag_q <= 1'b1;
    end else if (isWr(regWrStrobe, regAddr, `UWD_OFS_STATUS) && regWrData[`UWD_ST_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cause_q <= CAUSE_NONE;
    end else if (extTrig) begin
      cause_q <= extCause;
    end else if (state_q == ST_FLAG) begin
      cause_q <= CAUSE_WDOG;
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  logic [`UWD_IRQ_W-1:0] irqSet;
  logic [`UWD_IRQ_W-1:0] irqClr;
  assign irqSet[`UWD_IRQ_TIMEOUT] = (state_q == ST_FLAG);
  assign irqSet[`UWD_IRQ_RECONF] = extTrig || (state_q == ST_LOAD);
  assign irqClr = isWr(regWrStrobe, regAddr, `UWD_OFS_IRQ_STAT) ? regWrData[`UWD_IRQ_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqMask_q <= '0;
    end else if (isWr(regWrStrobe, regAddr, `UWD_OFS_IRQ_MASK)) begin
      irqMask_q <= regWrData[`UWD_IRQ_W-1:0];
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= '0;
    end else if (regRdStrobe) begin
      unique case (regAddr)
        `UWD_OFS_CTRL: regRdData <= {18'h00000, ctrl_q};
        `UWD_OFS_UPDATE: regRdData <= {18'h00000, update_q};
        `UWD_OFS_STATUS: regRdData <= {27'h0000000, (state_q == ST_RUN), cause_q, flag_q};
        `UWD_OFS_COUNT: regRdData <= {3'h0, cnt_q};
        `UWD_OFS_IRQ_STAT: regRdData <= {30'h00000000, irqStat_q};
        `UWD_OFS_IRQ_MASK: regRdData <= {30'h00000000, irqMask_q};
        default: regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_flagThenLoad;
    (state_q == ST_FLAG) && flag_q ##1 (state_q == ST_LOAD) && factoryLoad;
  endsequence

  sequence s_runStart;
    (state_q == ST_IDLE) ##1 (state_q == ST_RUN);
  endsequence

  // Load value is the timeout seen in the cycle of the load, not a later write
  a_start_value: assert property (s_runStart |-> cnt_q == uwdLoad($past(tmoVal)))
    else $error("watchdog did not start from the programmed timeout");
  a_count_step: assert property ((state_q == ST_RUN) && userModeS && tick && !reloadFire && !extTrig
      && cnt_q != '0 |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("counter did not step down by one on a tick");
  a_low_pattern: assert property ((state_q == ST_RUN) && reloadFire && !extTrig
      |=> cnt_q[`UWD_LOW_W-1:0] == `UWD_LOW_PATTERN)
    else $error("reload value lost the fixed low pattern");
  a_user_mode: assert property ((state_q == ST_RUN) |-> $past(userModeS))
    else $error("watchdog counting outside user mode");
  a_reload_hold: assert property (reloadFire |-> $past(reloadLow, 12) && $past(reloadLow, 1))
    else $error("reload accepted from a strobe shorter than the minimum");
  a_expire_seq: assert property ((state_q == ST_RUN) && userModeS && cnt_q == '0 && !reloadFire
      && !extTrig ##1 !extTrig |-> s_flagThenLoad)
    else $error("expiry did not flag then load the factory image");
  a_flag_before: assert property ($rose(factoryLoad) |-> $past(flag_q) && (cause_q == CAUSE_WDOG))
    else $error("factory load started before the status update");
  a_ctrl_clear: assert property (factoryLoad && !extTrig |=> ctrl_q == '0)
    else $error("control register not cleared after watchdog reconfiguration");
  a_core_update: assert property (coreReconfig && !trigCfgReq && !trigStat && !crcError
      |=> ctrl_q == $past(update_q))
    else $error("core reconfiguration did not take the update register");
  a_reload_restore: assert property ((state_q == ST_RUN) && userModeS && reloadFire && !extTrig
      |=> cnt_q == uwdLoad($past(tmoVal)) && (state_q == ST_RUN) ##1 (state_q != ST_FLAG) [*1])
    else $error("reload did not restore the programmed timeout");

endmodule // uwd_watchdog

//--- rtl/uwd_cfg.svh
// Constants of the user watchdog: register map, field layout, timing.
// Assumes a single 50 MHz system clock.
`ifndef UWD_CFG_SVH
`define UWD_CFG_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define UWD_ADDR_W 8
`define UWD_OFS_CTRL 8'h00
`define UWD_OFS_UPDATE 8'h04
`define UWD_OFS_STATUS 8'h08
`define UWD_OFS_COUNT 8'h0C
`define UWD_OFS_IRQ_STAT 8'h10
`define UWD_OFS_IRQ_MASK 8'h14

// ****************************************
// Field layout
// ****************************************
`define UWD_TMO_W 12
`define UWD_CNT_W 29
`define UWD_LOW_W 17
`define UWD_LOW_PATTERN 17'h00008
`define UWD_CTRL_W 14
`define UWD_CTRL_CLKSEL 12
`define UWD_CTRL_ENABLE 13
`define UWD_CTRL_RESET 14'h0000
`define UWD_ST_FLAG 0
`define UWD_ST_CAUSE_LO 1
`define UWD_ST_RUN 4
`define UWD_IRQ_W 2
`define UWD_IRQ_TIMEOUT 0
`define UWD_IRQ_RECONF 1

// ****************************************
// Timing
// ****************************************
`define UWD_CLK_PERIOD_NS 20
`define UWD_RELOAD_MIN_NS 250
`define UWD_RELOAD_CYC ((`UWD_RELOAD_MIN_NS + `UWD_CLK_PERIOD_NS - 1) / `UWD_CLK_PERIOD_NS)
`define UWD_HOLD_W 4

`endif

//--- rtl/uwd_pkg.sv
// Types shared by the user watchdog.
// Assumes uwd_cfg.svh is compiled alongside.
package uwd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_FLAG,
    ST_LOAD,
    ST_EXIT
  } uwd_state_e;

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_CFGREQ,
    CAUSE_STATUS,
    CAUSE_CORE,
    CAUSE_CRC,
    CAUSE_WDOG
  } uwd_cause_e;
endpackage

//--- tb/uwd_app_model.sv
// Application logic model: strobes the active-low watchdog reload pin.
// Assumes one clk domain; kick is a one-cycle request from the bench.
`timescale 1ns/100ps

module uwd_app_model (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Control from bench
  input wire logic kick,
  input wire logic [7:0] holdCyc,
  // Pin to device
  output logic reloadN
);
  logic [7:0] holdCnt_q;

  // ****************************************
  // Reload strobe, held low for holdCyc cycles
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      holdCnt_q <= 8'h00;
    end else if (kick && holdCnt_q == 8'h00) begin
      holdCnt_q <= holdCyc;
    end else if (holdCnt_q != 8'h00) begin
      holdCnt_q <= holdCnt_q - 8'h01;
    end
  end

  // Pin is driven high by the model when not strobed
  assign reloadN = (holdCnt_q == 8'h00);
endmodule // uwd_app_model

//--- tb/user_watchdog_reconfig_trigger_bench.sv
// Self-checking bench of the user watchdog: register port, reload, expiry, triggers.
// Assumes uwd_pkg, uwd_cfg.svh and the application model are compiled first.
`timescale 1ns/100ps
`include "uwd_cfg.svh"

module user_watchdog_reconfig_trigger_bench;
  import uwd_pkg::*;
  logic clk = 1'b0, sysRst = 1'b1, regWrStrobe = 1'b0, regRdStrobe = 1'b0;
  logic [7:0] regAddr = 8'h00, holdCyc = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData, seed = 32'h57, upd;
  logic reloadN, intOsc = 1'b0, usrClk = 1'b0, userMode = 1'b0, cfgReqN = 1'b1, cfgStN = 1'b1;
  logic crcErr = 1'b0, coreRe = 1'b0, wdTmo, facLoad, irq, kick = 1'b0, oscRun = 1'b0, useUsr = 1'b0;
  logic rdValid = 1'b0, wdtPrev = 1'b0;
  logic [1:0] oscDiv = 2'h0;
  logic [31:0] expQ[$];
  int nErrors = 0, totalChecks = 0, wdtSeen = 0, cyc = 0;

  always #10 clk = ~clk;

  uwd_app_model u_app (.clk(clk), .sys_rst(sysRst), .kick(kick), .holdCyc(holdCyc), .reloadN(reloadN));

  uwd_watchdog u_dut (.clk(clk), .sys_rst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .watchdog_reload_n(reloadN), .intOscClk(intOsc), .user_clock_pin(usrClk), .userMode(userMode),
    .config_request_n(cfgReqN), .config_status_n(cfgStN), .crcError(crcErr), .coreReconfig(coreRe),
    .watchdogTimeout(wdTmo), .factoryLoad(facLoad), .irq(irq));

  // ****************************************
  // Compare and verdict
  // ****************************************
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic giveVerdict();
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // Bus master and stimulus helpers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge clk);
    regWrStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    expQ.push_back(exp);
    @(posedge clk);
    regRdStrobe <= 1'b0;
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Irq is combinational from registers: look after the edge settles
  task automatic checkIrq(input logic exp);
    @(negedge clk);
    check_val({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic kicks(input int n, input logic [7:0] h, input int stopAt);
    repeat (n) begin
      if (wdtSeen < stopAt) begin
        @(posedge clk);
        holdCyc <= h;
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        waitCyc(22);
      end
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Tick source: toggles every 2 clk, kept well under the sampling limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    oscDiv <= oscDiv + 2'h1;
    if (oscRun && oscDiv[0]) begin
      if (useUsr) usrClk <= ~usrClk;
      else intOsc <= ~intOsc;
    end
  end

  // ****************************************
  // Output watcher
  // ****************************************
  always @(posedge clk) rdValid <= regRdStrobe;

  always @(negedge clk) begin
    if (rdValid) begin
      if (expQ.size() == 0) check_val(regRdData, 32'hFFFF_FFFF);
      else check_val(regRdData, expQ.pop_front());
    end
    if (wdtPrev || facLoad) check_val({31'h0, facLoad}, {31'h0, wdtPrev});
    if (wdTmo) wdtSeen++;
    wdtPrev <= wdTmo;
  end

  always @(posedge clk) begin
    if (cyc == 20000) begin
      nErrors++;
      giveVerdict();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  logic [31:0] stWd;
  int cause[4] = '{CAUSE_CFGREQ, CAUSE_STATUS, CAUSE_CRC, CAUSE_CORE};

  initial begin
    stWd = (32'(CAUSE_WDOG) << `UWD_ST_CAUSE_LO) | 32'h1;
    waitCyc(10);
    sysRst <= 1'b0;
    rd(`UWD_OFS_CTRL, 32'h0);
    rd(`UWD_OFS_STATUS, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    wr(`UWD_OFS_IRQ_MASK, 32'h3);
    rd(`UWD_OFS_IRQ_MASK, 32'h3);
    wr(`UWD_OFS_CTRL, 32'h2000);
    rd(`UWD_OFS_CTRL, 32'h2000);
    waitCyc(8);
    rd(`UWD_OFS_STATUS, 32'h0);
    userMode <= 1'b1;
    waitCyc(6);
    rd(`UWD_OFS_STATUS, 32'h10);
    rd(`UWD_OFS_COUNT, 32'(`UWD_LOW_PATTERN));
    oscRun <= 1'b1;
    kicks(10, 8'd14, 1);
    check_val(32'(wdtSeen), 32'h0);
    kicks(12, 8'd11, 1);
    check_val(32'(wdtSeen), 32'h1);
    waitCyc(5);
    rd(`UWD_OFS_STATUS, stWd);
    rd(`UWD_OFS_CTRL, 32'h0);
    rd(`UWD_OFS_IRQ_STAT, 32'h3);
    checkIrq(1'b1);
    wr(`UWD_OFS_IRQ_MASK, 32'h0);
    checkIrq(1'b0);
    wr(`UWD_OFS_IRQ_MASK, 32'h3);
    checkIrq(1'b1);
    wr(`UWD_OFS_IRQ_STAT, 32'h3);
    checkIrq(1'b0);
    wr(`UWD_OFS_STATUS, 32'h1);
    rd(`UWD_OFS_STATUS, stWd & 32'hFFFF_FFFE);
    // Second run ticks from the user clock pin
    oscRun <= 1'b0;
    userMode <= 1'b0;
    waitCyc(5);
    wr(`UWD_OFS_CTRL, 32'h3000);
    useUsr <= 1'b1;
    userMode <= 1'b1;
    oscRun <= 1'b1;
    for (int i = 0; i < 300 && wdtSeen < 2; i++) @(posedge clk);
    check_val(32'(wdtSeen), 32'h2);
    waitCyc(5);
    rd(`UWD_OFS_STATUS, stWd);
    wr(`UWD_OFS_STATUS, 32'h1);
    for (int t = 0; t < 4; t++) begin
      seed = xs(seed);
      upd = seed & 32'h3FFF;
      wr(`UWD_OFS_UPDATE, upd);
      wr(`UWD_OFS_CTRL, 32'h2001);
      @(posedge clk);
      case (t)
        0: cfgReqN <= 1'b0;
        1: cfgStN <= 1'b0;
        2: crcErr <= 1'b1;
        default: coreRe <= 1'b1;
      endcase
      @(posedge clk);
      crcErr <= 1'b0;
      coreRe <= 1'b0;
      waitCyc(3);
      cfgReqN <= 1'b1;
      cfgStN <= 1'b1;
      waitCyc(3);
      rd(`UWD_OFS_STATUS, 32'(cause[t]) << `UWD_ST_CAUSE_LO);
      rd(`UWD_OFS_CTRL, (t == 3) ? upd : 32'h0);
    end
    // Disabled watchdog must stay idle in user mode
    userMode <= 1'b0;
    waitCyc(4);
    wr(`UWD_OFS_CTRL, 32'h0);
    userMode <= 1'b1;
    waitCyc(6);
    rd(`UWD_OFS_STATUS, 32'(CAUSE_CORE) << `UWD_ST_CAUSE_LO);
    waitCyc(4);
    giveVerdict();
  end
endmodule // user_watchdog_reconfig_trigger_bench
